/* File: rtl/wake_seq_pkg.sv */
// constants and types shared by the stack wake-up sequencer
// What this block does
// - power-up turns on reference, then shutdown
// - regulator output on after fixed delay
// - wake from shutdown enables core supplies, active
// - active after wake sends wake tone upward
// - detected tone repeats wake and forwarding steps
// - wake command from sleep reloads defaults
// - reload finishes within sleep-to-active setup time
// - sleep-exit command keeps register contents
// - sleep-exit entry sends sleep-exit tone upward
// - at most 40 sleep-exit tone repetitions
// - forwarded bits re-timed to local clock
package wake_seq_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_DELAY_NS = 1000;
  localparam int POR_DELAY_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TONE_PERIOD_NS = 1000;
  localparam int TONE_PERIOD_CYC = TONE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TONE_HIGH_CYC = TONE_PERIOD_CYC / 2;
  localparam int HOLD_TIME_NS = 2000;
  localparam int HOLD_TIME_CYC = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_TIME_NS = 500;
  localparam int SETUP_TIME_CYC = SETUP_TIME_NS / CLK_PERIOD_NS;
  localparam int RELOAD_CYC = 4;
  localparam int WAKE_DET_COUNT = 4;
  localparam int EXIT_DET_COUNT = 3;
  localparam int WAKE_TONE_REPS = 10;
  localparam int EXIT_TONE_REPS = 40;
  localparam int MAX_TONE_REPS = 40;
  localparam int CNT_W = 16;
  typedef enum logic [1:0] {TONE_NONE, TONE_WAKE, TONE_EXIT} tone_kind_t;
  typedef enum {ST_POWERUP, ST_SHUTDOWN, ST_SLEEP, ST_RELOAD, ST_ACTIVE} pwr_state_t;
endpackage

/* File: rtl/tone_detect.sv */
// tone detector: counts consecutive valid tone periods on the incoming line
`timescale 1ns/1ps
`default_nettype none
module tone_detect
  import wake_seq_pkg::*;
#(
  parameter int WAKE_COUNT = WAKE_DET_COUNT,
  parameter int EXIT_COUNT = EXIT_DET_COUNT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // line from the device below
  input wire logic tone_in,
  input wire logic tone_is_exit,
  // detection pulses
  output logic wake_seen,
  output logic exit_seen
);
  logic prev_in;
  logic [CNT_W-1:0] gap;
  logic [7:0] periods;
  logic last_exit;
  logic rise;

  assign rise = tone_in && !prev_in;

  // edge history
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prev_in <= 1'b0;
    end else begin
      prev_in <= tone_in;
    end
  end

  // period counting; a rise too late or early breaks the run
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      gap <= '0;
      periods <= '0;
      last_exit <= 1'b0;
      wake_seen <= 1'b0;
      exit_seen <= 1'b0;
    end else begin
      wake_seen <= 1'b0;
      exit_seen <= 1'b0;
      if (rise) begin
        gap <= CNT_W'(1);
        if (periods == 8'h00 || (gap == CNT_W'(TONE_PERIOD_CYC) && last_exit == tone_is_exit)) begin
          periods <= periods + 8'h01;
          if (tone_is_exit && 32'(periods) + 1 == EXIT_COUNT) begin
            exit_seen <= 1'b1;
          end
          if (!tone_is_exit && 32'(periods) + 1 == WAKE_COUNT) begin
            wake_seen <= 1'b1;
          end
        end else begin
          periods <= 8'h01;
        end
        last_exit <= tone_is_exit;
      end else if (gap > CNT_W'(TONE_PERIOD_CYC)) begin
        periods <= '0;
      end else begin
        gap <= gap + CNT_W'(1);
      end
    end
  end

  // one detection per run of periods
  a_detect_threshold: assert property (@(posedge core_clk) disable iff (!rstn)
    wake_seen |-> $past(periods) == 8'(WAKE_COUNT - 1))
    else $error("wake detect before threshold");

  a_exit_threshold: assert property (@(posedge core_clk) disable iff (!rstn)
    exit_seen |-> $past(periods) == 8'(EXIT_COUNT - 1))
    else $error("exit detect before threshold");
endmodule
`default_nettype wire

/* File: rtl/stack_wakeup_sequencer.sv */
// power and wake sequencer for one device of a daisy-chained stack
`timescale 1ns/1ps
`default_nettype none
module stack_wakeup_sequencer
  import wake_seq_pkg::*;
#(
  parameter int POR_CYC = POR_DELAY_CYC,
  parameter int HOLD_CYC = HOLD_TIME_CYC,
  parameter int EXIT_REPS = EXIT_TONE_REPS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // host side
  input wire logic wake_request,
  input wire logic uart_rx,
  input wire logic sleep_request,
  // tone from the device below
  input wire logic tone_in,
  input wire logic tone_in_is_exit,
  // data bits from below, to be forwarded upward
  input wire logic chain_bit_in,
  // supply and reference enables, ready, active and reload flags
  output logic always_on_reference,
  output logic regulator_output,
  output logic analog_core_supply,
  output logic digital_core_supply,
  output logic comm_ready,
  output logic device_active,
  output logic defaults_reload,
  // tone and data toward the device above
  output logic tone_out,
  output logic tone_out_is_exit,
  output logic chain_bit_out
);
  pwr_state_t state;
  logic [CNT_W-1:0] por_cnt;
  logic [CNT_W-1:0] hold_cnt;
  logic [CNT_W-1:0] step_cnt;
  logic [CNT_W-1:0] tone_cnt;
  logic [7:0] tone_reps;
  logic [7:0] tone_target;
  logic tone_busy;
  logic wake_seen;
  logic exit_seen;
  logic exit_cmd;
  logic wake_cmd;
  logic start_tone;
  logic start_exit;
  logic chain_meta;

  // assertion spans; delay bounds must be constants of this file
  localparam int RELOAD_SPAN = RELOAD_CYC;
  localparam int SETUP_SPAN = SETUP_TIME_CYC;

  tone_detect u_detect (
    .core_clk(core_clk),
    .rstn(rstn),
    .tone_in(tone_in),
    .tone_is_exit(tone_in_is_exit),
    .wake_seen(wake_seen),
    .exit_seen(exit_seen)
  );

  assign wake_cmd = wake_request || wake_seen;
  assign exit_cmd = (hold_cnt == CNT_W'(HOLD_CYC)) || exit_seen;

  // receive line held low counts toward the sleep-exit command
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hold_cnt <= '0;
    end else if (uart_rx || state != ST_SLEEP) begin
      hold_cnt <= '0;
    end else if (hold_cnt != CNT_W'(HOLD_CYC)) begin
      hold_cnt <= hold_cnt + CNT_W'(1);
    end
  end

  // power-on delay before the regulator output turns on
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      por_cnt <= '0;
      regulator_output <= 1'b0;
      comm_ready <= 1'b0;
    end else if (por_cnt != CNT_W'(POR_CYC)) begin
      por_cnt <= por_cnt + CNT_W'(1);
    end else begin
      regulator_output <= 1'b1;
      comm_ready <= 1'b1;
    end
  end

  // main power state machine
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= ST_POWERUP;
      step_cnt <= '0;
      always_on_reference <= 1'b0;
      analog_core_supply <= 1'b0;
      digital_core_supply <= 1'b0;
      device_active <= 1'b0;
      defaults_reload <= 1'b0;
      start_tone <= 1'b0;
      start_exit <= 1'b0;
    end else begin
      start_tone <= 1'b0;
      start_exit <= 1'b0;
      unique case (state)
        ST_POWERUP: begin
          always_on_reference <= 1'b1;
          state <= ST_SHUTDOWN;
        end
        ST_SHUTDOWN: begin
          if (wake_cmd && comm_ready) begin
            analog_core_supply <= 1'b1;
            digital_core_supply <= 1'b1;
            device_active <= 1'b1;
            start_tone <= 1'b1;
            state <= ST_ACTIVE;
          end
        end
        ST_SLEEP: begin
          if (wake_cmd) begin
            defaults_reload <= 1'b1;
            step_cnt <= '0;
            state <= ST_RELOAD;
          end else if (exit_cmd) begin
            analog_core_supply <= 1'b1;
            digital_core_supply <= 1'b1;
            device_active <= 1'b1;
            start_tone <= 1'b1;
            start_exit <= 1'b1;
            state <= ST_ACTIVE;
          end
        end
        ST_RELOAD: begin
          // reload is bounded well inside the setup time
          step_cnt <= step_cnt + CNT_W'(1);
          if (step_cnt == CNT_W'(RELOAD_CYC - 1)) begin
            defaults_reload <= 1'b0;
            analog_core_supply <= 1'b1;
            digital_core_supply <= 1'b1;
            device_active <= 1'b1;
            start_tone <= 1'b1;
            state <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (sleep_request) begin
            analog_core_supply <= 1'b0;
            digital_core_supply <= 1'b0;
            device_active <= 1'b0;
            state <= ST_SLEEP;
          end
        end
      endcase
    end
  end

  // tone generator toward the next device up
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tone_busy <= 1'b0;
      tone_cnt <= '0;
      tone_reps <= '0;
      tone_target <= '0;
      tone_out <= 1'b0;
      tone_out_is_exit <= 1'b0;
    end else if (start_tone) begin
      tone_busy <= 1'b1;
      tone_cnt <= '0;
      tone_reps <= '0;
      // sleep-exit burst is capped whatever the parameter says
      tone_target <= start_exit ? 8'(EXIT_REPS > MAX_TONE_REPS ? MAX_TONE_REPS : EXIT_REPS)
                                : 8'(WAKE_TONE_REPS);
      tone_out_is_exit <= start_exit;
      tone_out <= 1'b1;
    end else if (tone_busy) begin
      if (tone_cnt == CNT_W'(TONE_PERIOD_CYC - 1)) begin
        tone_cnt <= '0;
        if (tone_reps + 8'h01 == tone_target) begin
          tone_busy <= 1'b0;
          tone_out <= 1'b0;
        end else begin
          tone_reps <= tone_reps + 8'h01;
          tone_out <= 1'b1;
        end
      end else begin
        tone_cnt <= tone_cnt + CNT_W'(1);
        if (tone_cnt == CNT_W'(TONE_HIGH_CYC - 1)) begin
          tone_out <= 1'b0;
        end
      end
    end
  end

  // re-time forwarded bits on the local clock so widths never shrink
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      chain_meta <= 1'b0;
      chain_bit_out <= 1'b0;
    end else begin
      chain_meta <= chain_bit_in;
      chain_bit_out <= chain_meta;
    end
  end

  // power-up settles in shutdown, never active
  a_powerup_shutdown: assert property (@(posedge core_clk) disable iff (!rstn)
    state == ST_POWERUP |=> state == ST_SHUTDOWN && always_on_reference)
    else $error("power-up did not settle in shutdown");

  // regulator waits for the full delay
  a_regulator_delay: assert property (@(posedge core_clk) disable iff (!rstn)
    regulator_output |-> por_cnt == CNT_W'(POR_CYC))
    else $error("regulator on early");

  // wake from shutdown raises both supplies and active together
  a_wake_supplies: assert property (@(posedge core_clk) disable iff (!rstn)
    state == ST_SHUTDOWN && wake_cmd && comm_ready |=>
      analog_core_supply && digital_core_supply && device_active)
    else $error("wake did not enable supplies");

  // a tone burst starts on entry to active
  a_tone_start: assert property (@(posedge core_clk) disable iff (!rstn)
    start_tone |=> tone_out && tone_busy)
    else $error("tone not started");

  // reload completes inside the setup time
  a_reload_bound: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(defaults_reload) |-> ##[1:SETUP_SPAN] device_active)
    else $error("reload exceeded setup time");

  // sleep-exit keeps registers: no reload pulse
  a_exit_noreload: assert property (@(posedge core_clk) disable iff (!rstn)
    state == ST_SLEEP && !wake_cmd && exit_cmd |=> !defaults_reload && device_active)
    else $error("sleep-exit reloaded defaults");

  // receive held low for the hold time becomes the command
  a_hold_exit: assert property (@(posedge core_clk) disable iff (!rstn)
    state == ST_SLEEP && !wake_cmd && hold_cnt == CNT_W'(HOLD_CYC) |-> ##2 tone_out_is_exit)
    else $error("hold did not start sleep-exit");

  // sleep-exit burst never goes past the cap
  a_exit_cap: assert property (@(posedge core_clk) disable iff (!rstn)
    tone_busy |-> tone_reps < 8'(MAX_TONE_REPS))
    else $error("too many tone repetitions");

  // forwarded bit is the input two clocks earlier
  a_retime: assert property (@(posedge core_clk) disable iff (!rstn)
    rstn && $past(rstn) |=> chain_bit_out == $past(chain_bit_in, 2))
    else $error("forwarded bit not re-timed");

  // shutdown is left only by an accepted wake
  a_shutdown_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    state == ST_SHUTDOWN && !(wake_cmd && comm_ready) |=> state == ST_SHUTDOWN && !device_active)
    else $error("shutdown left without wake");

  // wake before the regulator is up is refused
  a_early_refused: assert property (@(posedge core_clk) disable iff (!rstn)
    state == ST_SHUTDOWN && !comm_ready |=> !device_active)
    else $error("wake taken before ready");

  // wake command in sleep goes through the reload
  a_sleep_reload: assert property (@(posedge core_clk) disable iff (!rstn)
    state == ST_SLEEP && wake_cmd |=> state == ST_RELOAD && defaults_reload && !device_active)
    else $error("wake from sleep skipped reload");

  // reload lasts its fixed span, then active
  a_reload_length: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(defaults_reload) |-> ##RELOAD_SPAN device_active && !defaults_reload)
    else $error("reload span wrong");

  // active never overlaps the reload
  a_reload_exclusive: assert property (@(posedge core_clk) disable iff (!rstn)
    !(defaults_reload && device_active))
    else $error("active during reload");

  // sleep-exit burst is of exit kind and capped
  a_exit_kind: assert property (@(posedge core_clk) disable iff (!rstn)
    start_tone && start_exit |=> tone_out_is_exit && tone_target <= 8'(MAX_TONE_REPS))
    else $error("sleep-exit burst wrong kind");

  // wake burst is of wake kind and length
  a_wake_kind: assert property (@(posedge core_clk) disable iff (!rstn)
    start_tone && !start_exit |=> !tone_out_is_exit && tone_target == 8'(WAKE_TONE_REPS))
    else $error("wake burst wrong kind");

  // tone is high for the first half of each period
  a_tone_half: assert property (@(posedge core_clk) disable iff (!rstn)
    tone_busy && tone_cnt == CNT_W'(TONE_HIGH_CYC - 1) && !start_tone |=> !tone_out)
    else $error("tone high too long");

  // reference stays on once turned on
  a_ref_stays: assert property (@(posedge core_clk) disable iff (!rstn)
    always_on_reference |=> always_on_reference)
    else $error("reference dropped");

  // ready for communication stays up
  a_comm_stays: assert property (@(posedge core_clk) disable iff (!rstn)
    comm_ready |=> comm_ready && regulator_output)
    else $error("communication ready dropped");

  // active always runs on both core supplies
  a_active_supplies: assert property (@(posedge core_clk) disable iff (!rstn)
    device_active |-> analog_core_supply && digital_core_supply)
    else $error("active without core supplies");
endmodule
`default_nettype wire

/* File: testbench/tone_source.sv */
// far-side model: the device below sending a burst of tone periods
`timescale 1ns/1ps
`default_nettype none
module tone_source
  import wake_seq_pkg::*;
(
  // clock
  input wire logic core_clk,
  // burst request from the bench
  input wire logic start,
  input wire logic [3:0] count,
  input wire logic exit_kind,
  // tone line toward the sequencer
  output logic tone,
  output logic tone_exit
);
  int per = 0;
  int left = 0;
  // one rise per period, high half of it; line idles low between bursts
  always @(posedge core_clk) begin
    if (start && left == 0) begin
      left <= int'(count);
      per <= 0;
      tone_exit <= exit_kind;
    end else if (left != 0) begin
      tone <= (per < TONE_HIGH_CYC);
      per <= (per == TONE_PERIOD_CYC - 1) ? 0 : per + 1;
      if (per == TONE_PERIOD_CYC - 1) left <= left - 1;
    end else begin
      tone <= 1'h0;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/stack_wakeup_sequencer_tb.sv */
// self-checking bench for the stack wake-up sequencer
`timescale 1ns/1ps
`default_nettype none
module stack_wakeup_sequencer_tb;
  import wake_seq_pkg::*;
  localparam int POR = 5;
  localparam int HOLD = 4;
  localparam int REPS = 45;
  typedef struct packed {logic slp; logic kind; logic [3:0] n; logic act; logic rel;} row_t;
  // bursts from below: start in sleep, kind, periods, expected wake and reload
  row_t rows [5] = '{'{1'h0, 1'h0, 4'h4, 1'h1, 1'h0}, '{1'h0, 1'h0, 4'h3, 1'h0, 1'h0},
    '{1'h1, 1'h1, 4'h3, 1'h1, 1'h0}, '{1'h1, 1'h1, 4'h2, 1'h0, 1'h0},
    '{1'h1, 1'h0, 4'h4, 1'h1, 1'h1}};
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic wake_request = 1'h0;
  logic uart_rx = 1'h1;
  logic sleep_request = 1'h0;
  logic chain_bit_in = 1'h0;
  logic src_start = 1'h0;
  logic src_kind = 1'h0;
  logic [3:0] src_n = 4'h0;
  logic tone_in, tone_in_is_exit, always_on_reference, regulator_output, analog_core_supply;
  logic digital_core_supply, comm_ready, device_active, defaults_reload, tone_out;
  logic tone_out_is_exit, chain_bit_out;
  logic tone_prev = 1'h0;
  int reloads = 0;
  logic [15:0] pat = 16'hB5C3;
  int rises = 0;
  int base_r = 0;
  int base_l = 0;
  int fail_count = 0;
  int check_count = 0;
  int n;

  initial forever #5 core_clk = ~core_clk;

  tone_source tone_source_i (.core_clk(core_clk), .start(src_start), .count(src_n),
    .exit_kind(src_kind), .tone(tone_in), .tone_exit(tone_in_is_exit));

  stack_wakeup_sequencer #(.POR_CYC(POR), .HOLD_CYC(HOLD), .EXIT_REPS(REPS))
    stack_wakeup_sequencer_i (.core_clk(core_clk), .rstn(rstn), .wake_request(wake_request),
    .uart_rx(uart_rx), .sleep_request(sleep_request), .tone_in(tone_in),
    .tone_in_is_exit(tone_in_is_exit), .chain_bit_in(chain_bit_in),
    .always_on_reference(always_on_reference), .regulator_output(regulator_output),
    .analog_core_supply(analog_core_supply), .digital_core_supply(digital_core_supply),
    .comm_ready(comm_ready), .device_active(device_active), .defaults_reload(defaults_reload),
    .tone_out(tone_out), .tone_out_is_exit(tone_out_is_exit), .chain_bit_out(chain_bit_out));

  // count outgoing tone rises and any reload pulse
  always @(posedge core_clk) begin
    tone_prev <= tone_out;
    if (tone_out && !tone_prev) rises <= rises + 1;
    if (defaults_reload) reloads <= reloads + 1;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // reset, with a wake pulse too early to be taken
  task automatic reset_dut();
    @(posedge core_clk) rstn <= 1'h0;
    cyc(3);
    check("held_off", {always_on_reference, regulator_output, device_active}, 16'h0);
    @(posedge core_clk) rstn <= 1'h1;
    wake_request <= 1'h1;
    repeat (2) @(posedge core_clk);
    wake_request <= 1'h0;
    cyc(1);
    check("ref_first", {always_on_reference, regulator_output, device_active}, 16'h4);
    n = 3;
    while (regulator_output !== 1'h1 && n < 50) begin
      cyc(1);
      n++;
    end
    check("por_delay", 16'(n), 16'(POR + 1));
    cyc(3);
    check("shutdown", {comm_ready, device_active}, 16'h2);
  endtask

  // sleep entry by one request cycle
  task automatic to_sleep();
    @(posedge core_clk) sleep_request <= 1'h1;
    @(posedge core_clk) sleep_request <= 1'h0;
    cyc(3);
  endtask

  initial begin
    foreach (rows[i]) begin
      reset_dut();
      if (rows[i].slp) begin
        @(posedge core_clk) wake_request <= 1'h1;
        @(posedge core_clk) wake_request <= 1'h0;
        cyc(WAKE_TONE_REPS * TONE_PERIOD_CYC + 20);
        to_sleep();
      end
      base_l = reloads;
      @(posedge core_clk) src_start <= 1'h1;
      src_kind <= rows[i].kind;
      src_n <= rows[i].n;
      @(posedge core_clk) src_start <= 1'h0;
      cyc(int'(rows[i].n) * TONE_PERIOD_CYC + 20);
      check("row_active", device_active, rows[i].act);
      check("row_reload", 16'(reloads != base_l), 16'(rows[i].rel));
      if (rows[i].act) check("row_kind", tone_out_is_exit, rows[i].kind);
    end
    // wake pulse from shutdown and its outgoing burst
    reset_dut();
    base_r = rises;
    @(posedge core_clk) wake_request <= 1'h1;
    @(posedge core_clk) wake_request <= 1'h0;
    cyc(0);
    check("wake_up", {device_active, analog_core_supply, digital_core_supply, tone_out,
      tone_out_is_exit}, 16'h1C);
    cyc(1);
    check("tone_first", {tone_out, tone_out_is_exit}, 16'h2);
    cyc(WAKE_TONE_REPS * TONE_PERIOD_CYC + 20);
    check("wake_burst", 16'(rises - base_r), 16'(WAKE_TONE_REPS));
    // receive line low one cycle short of the hold time must not wake
    to_sleep();
    @(posedge core_clk) uart_rx <= 1'h0;
    repeat (HOLD - 1) @(posedge core_clk);
    uart_rx <= 1'h1;
    cyc(3);
    check("short_hold", device_active, 1'h0);
    base_l = reloads;
    base_r = rises;
    @(posedge core_clk) uart_rx <= 1'h0;
    repeat (HOLD) @(posedge core_clk);
    uart_rx <= 1'h1;
    cyc(2);
    check("exit_up", {device_active, analog_core_supply, digital_core_supply,
      tone_out_is_exit}, 16'hF);
    cyc(REPS * TONE_PERIOD_CYC + 20);
    check("exit_burst", 16'(rises - base_r), 16'(MAX_TONE_REPS));
    check("exit_keep", 16'(reloads != base_l), 16'h0);
    // wake command from sleep goes through the reload first
    to_sleep();
    @(posedge core_clk) wake_request <= 1'h1;
    @(posedge core_clk) wake_request <= 1'h0;
    cyc(0);
    check("reload_on", {defaults_reload, device_active}, 16'h2);
    n = 0;
    while (device_active !== 1'h1 && n < SETUP_TIME_CYC) begin
      cyc(1);
      n++;
    end
    check("reload_time", 16'(n), 16'(RELOAD_CYC));
    check("reload_off", defaults_reload, 1'h0);
    // forwarded bits leave two clocks later, never shortened
    for (int i = 0; i < 18; i++) begin
      @(posedge core_clk) chain_bit_in <= pat[i % 16];
      cyc(0);
      if (i >= 2) check("chain_bit", chain_bit_out, pat[i - 2]);
    end
    print_verdict();
  end

  // all bursts together come to about 10500 cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
